/* File: lcfm_fault_mgr.sv */
// LED channel fault manager: per-string time-outs, thermal shutdown, regulation choice.
// Assumes comparator and PWM tick inputs synchronous to pclk; APB slave, zero wait.
// Contract
// R1: Sink above short threshold times out after 6 periods, 7-18 direct.
// R2: Short below threshold without thermal trip keeps channel on; highest drop regulates.
// R3: Thermal trip with low-side short turns all channels off until power cycle.
// R4: Open string drives output to limit, then times out and switches off.
// R5: Zener-bypassed open string is not faulted and becomes regulation reference.
// R6: Thermal trip with zener-bypassed string turns that and all channels off.
// R7: Other channel pushed above short threshold is switched off after time-out.
// R8: Thermal trip from drop mismatch turns all channels off until cooled.
// R9: Output at overvoltage limit marks every not-yet-good channel open at once.
// R10: Input lockout resets everything; restart needs a new enable. Mask, latch and time-out registers keep their values.
// R11: Each channel counts PWM periods while faulty, clears when fault goes.
`timescale 1ns/100ps
`include "lcfm_defs.svh"
module lcfm_fault_mgr (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire lcfm_pkg::lcfm_sense_t [3:0] sense,
    input wire logic pwm_period_tick,
    input wire logic direct_pwm_mode,
    input wire logic overtemp_trip,
    input wire logic output_overvoltage_limit,
    input wire logic input_undervoltage_lockout,
    output logic [3:0] led_channel_en,
    output logic boost_en,
    output logic [1:0] reg_ref_chan
);
    lcfm_pkg::lcfm_state_t state_r, state_nxt;
    lcfm_pkg::lcfm_status_t stat;
    logic en_r, en_nxt, latch_r, latch_nxt;
    logic [4:0] dtmo_r, dtmo_nxt, lim, lim_m1;
    logic [3:0] mask_r, mask_nxt;
    logic [3:0] good_r, good_nxt, open_r, open_nxt, faulted_r, faulted_nxt;
    logic [3:0] active, fcond, led_nxt;
    logic [4:0] cnt_r [4];
    logic [4:0] cnt_nxt [4];
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt, boost_nxt, wr;
    logic [1:0] ref_nxt;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    assign wr = psel & penable & pready & pwrite;

    // Software registers and APB answer
    always_comb begin
        en_nxt = en_r;
        latch_nxt = latch_r;
        dtmo_nxt = dtmo_r;
        mask_nxt = mask_r;
        if (wr) begin
            if (paddr == `LCFM_OFF_CTRL) begin
                en_nxt = pwdata[`LCFM_CTRL_EN];
                latch_nxt = pwdata[`LCFM_CTRL_LATCH];
                dtmo_nxt = pwdata[`LCFM_CTRL_TMO_LSB +: 5];
            end else if (paddr == `LCFM_OFF_MASK) begin
                mask_nxt = pwdata[3:0];
            end
        end
        if (input_undervoltage_lockout) begin
            en_nxt = 1'b0; // R10
        end
    end

    always_comb begin
        stat = '0;
        stat.ref_chan = reg_ref_chan;
        stat.state = state_r;
        stat.direct = direct_pwm_mode;
        stat.otp = overtemp_trip;
        stat.good = good_r;
        stat.faulted = faulted_r;
        stat.on = led_channel_en;
        prdata_nxt = prdata;
        pready_nxt = psel & ~penable;
        pslverr_nxt = 1'b0;
        if (psel & ~penable) begin
            prdata_nxt = 32'h0000_0000;
            if (paddr == `LCFM_OFF_CTRL) begin
                prdata_nxt[`LCFM_CTRL_EN] = en_r;
                prdata_nxt[`LCFM_CTRL_LATCH] = latch_r;
                prdata_nxt[`LCFM_CTRL_TMO_LSB +: 5] = dtmo_r;
            end else if (paddr == `LCFM_OFF_MASK) begin
                prdata_nxt[3:0] = mask_r;
            end else if (paddr == `LCFM_OFF_STAT) begin
                prdata_nxt = stat;
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    // Direct PWM time-out is clamped into its legal window
    always_comb begin
        lim = `LCFM_TMO_PWM; // R1
        if (direct_pwm_mode) begin
            if (dtmo_r < `LCFM_DTMO_MIN) begin
                lim = `LCFM_DTMO_MIN;
            end else if (dtmo_r > `LCFM_DTMO_MAX) begin
                lim = `LCFM_DTMO_MAX;
            end else begin
                lim = dtmo_r;
            end
        end
        lim_m1 = 5'(lim - 5'h01);
    end

    // Supervisor: off, running, thermal hold, latched shutdown
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            lcfm_pkg::LCFM_OFF: begin
                if (en_r) begin
                    state_nxt = overtemp_trip ? lcfm_pkg::LCFM_HOLD : lcfm_pkg::LCFM_RUN;
                end
            end
            lcfm_pkg::LCFM_RUN: begin
                if (overtemp_trip) begin
                    state_nxt = latch_r ? lcfm_pkg::LCFM_LOCK : lcfm_pkg::LCFM_HOLD; // R3 R6 R8
                end
            end
            lcfm_pkg::LCFM_HOLD: begin
                if (!overtemp_trip) begin
                    state_nxt = lcfm_pkg::LCFM_RUN; // R8
                end
            end
            default: state_nxt = lcfm_pkg::LCFM_LOCK; // R3
        endcase
        if (input_undervoltage_lockout) begin
            state_nxt = lcfm_pkg::LCFM_OFF; // R10
        end else if (!en_r && state_r != lcfm_pkg::LCFM_LOCK) begin
            state_nxt = lcfm_pkg::LCFM_OFF;
        end
    end

    // Per-channel open detection, time-out counter and fault latch
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ch
            assign active[g] = (state_r == lcfm_pkg::LCFM_RUN) & mask_r[g] & ~faulted_r[g];
            assign fcond[g] = active[g] & (sense[g].over_short | open_r[g]); // R1 R4 R7
            always_comb begin
                good_nxt[g] = good_r[g] | (active[g] & sense[g].at_target);
                open_nxt[g] = open_r[g];
                if (!active[g] || sense[g].at_target) begin
                    open_nxt[g] = 1'b0; // R2 R5
                end else if (good_r[g] || output_overvoltage_limit) begin
                    open_nxt[g] = 1'b1; // R4 R9
                end
                cnt_nxt[g] = cnt_r[g];
                if (!fcond[g]) begin
                    cnt_nxt[g] = 5'h00; // R11
                end else if (pwm_period_tick) begin
                    cnt_nxt[g] = 5'(cnt_r[g] + 5'h01); // R11
                end
                faulted_nxt[g] = faulted_r[g] | (fcond[g] & pwm_period_tick & (cnt_r[g] == lim_m1)); // R1 R4 R7
                if (state_r == lcfm_pkg::LCFM_OFF) begin
                    good_nxt[g] = 1'b0;
                    faulted_nxt[g] = 1'b0; // R10
                end
                led_nxt[g] = (state_nxt == lcfm_pkg::LCFM_RUN) & mask_nxt[g] & ~faulted_nxt[g]; // R6
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    good_r[g] <= 1'b0;
                    open_r[g] <= 1'b0;
                    faulted_r[g] <= 1'b0;
                    cnt_r[g] <= 5'h00;
                    led_channel_en[g] <= 1'b0;
                end else begin
                    good_r[g] <= good_nxt[g];
                    open_r[g] <= open_nxt[g];
                    faulted_r[g] <= faulted_nxt[g];
                    cnt_r[g] <= cnt_nxt[g];
                    led_channel_en[g] <= led_nxt[g];
                end
            end

            property p_expire;
                fcond[g] && pwm_period_tick && cnt_r[g] == lim_m1 |=> faulted_r[g] && !led_channel_en[g];
            endproperty
            a_expire: assert property (p_expire) else $error("channel not off at time-out"); // R1
            property p_no_early;
                fcond[g] && pwm_period_tick && cnt_r[g] < lim_m1 |=> !faulted_r[g];
            endproperty
            a_no_early: assert property (p_no_early) else $error("channel faulted early"); // R7
            property p_cnt_step;
                fcond[g] && pwm_period_tick && cnt_r[g] < lim_m1 |=> cnt_r[g] == 5'($past(cnt_r[g]) + 5'h01);
            endproperty
            a_cnt_step: assert property (p_cnt_step) else $error("time-out counter did not step"); // R11
            property p_cnt_clr;
                !fcond[g] |=> cnt_r[g] == 5'h00;
            endproperty
            a_cnt_clr: assert property (p_cnt_clr) else $error("time-out counter not cleared"); // R11
            property p_limit_open;
                active[g] && output_overvoltage_limit && !good_r[g] && !sense[g].at_target |=> open_r[g];
            endproperty
            a_limit_open: assert property (p_limit_open) else $error("not-good channel not open at limit"); // R9
            property p_cnt_hold;
                fcond[g] && !pwm_period_tick |=> cnt_r[g] == $past(cnt_r[g]);
            endproperty
            a_cnt_hold: assert property (p_cnt_hold) else $error("time-out counter moved without tick"); // R11
            property p_open_off;
                open_r[g] && active[g] && pwm_period_tick && cnt_r[g] == lim_m1 |=> !led_channel_en[g];
            endproperty
            a_open_off: assert property (p_open_off) else $error("open channel still on"); // R4
            property p_zener;
                active[g] && sense[g].at_target |=> !open_r[g];
            endproperty
            a_zener: assert property (p_zener) else $error("regulating channel seen as open"); // R5
            property p_keep;
                active[g] && !sense[g].over_short && !open_r[g] && state_nxt == lcfm_pkg::LCFM_RUN && mask_nxt[g]
                    |=> led_channel_en[g];
            endproperty
            a_keep: assert property (p_keep) else $error("healthy channel switched off"); // R2
        end
    endgenerate

    // Regulation follows the highest forward drop among lit strings
    always_comb begin
        ref_nxt = reg_ref_chan;
        for (int i = 0; i < 4; i++) begin
            if (led_channel_en[i] && (!led_channel_en[ref_nxt] ||
                sense[i].string_forward_drop > sense[ref_nxt].string_forward_drop)) begin
                ref_nxt = 2'(i); // R2 R5
            end
        end
        boost_nxt = (state_nxt == lcfm_pkg::LCFM_RUN);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= lcfm_pkg::LCFM_OFF;
            en_r <= `LCFM_EN_RST;
            latch_r <= `LCFM_LATCH_RST;
            dtmo_r <= `LCFM_DTMO_RST;
            mask_r <= `LCFM_MASK_RST;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            boost_en <= 1'b0;
            reg_ref_chan <= 2'h0;
        end else begin
            state_r <= state_nxt;
            en_r <= en_nxt;
            latch_r <= latch_nxt;
            dtmo_r <= dtmo_nxt;
            mask_r <= mask_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            boost_en <= boost_nxt;
            reg_ref_chan <= ref_nxt;
        end
    end

    property p_otp_off;
        overtemp_trip |=> led_channel_en == 4'h0 && !boost_en;
    endproperty
    a_otp_off: assert property (p_otp_off) else $error("channels lit during thermal trip"); // R6
    property p_otp_lock;
        state_r == lcfm_pkg::LCFM_RUN && overtemp_trip && latch_r && en_r && !input_undervoltage_lockout
            |=> state_r == lcfm_pkg::LCFM_LOCK ##1 led_channel_en == 4'h0;
    endproperty
    a_otp_lock: assert property (p_otp_lock) else $error("no latched shutdown"); // R3
    property p_lock_hold;
        state_r == lcfm_pkg::LCFM_LOCK && !input_undervoltage_lockout |=> state_r == lcfm_pkg::LCFM_LOCK;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("latched shutdown released"); // R3
    property p_cool;
        state_r == lcfm_pkg::LCFM_HOLD && !overtemp_trip && en_r && !input_undervoltage_lockout
            |=> state_r == lcfm_pkg::LCFM_RUN;
    endproperty
    a_cool: assert property (p_cool) else $error("no restart after cooling"); // R8
    property p_lockout;
        input_undervoltage_lockout |=> state_r == lcfm_pkg::LCFM_OFF && !en_r ##1 faulted_r == 4'h0;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout did not reset"); // R10

    // Outside RUN the sinks and the boost stage stay dark
    property p_dark;
        state_r != lcfm_pkg::LCFM_RUN |-> led_channel_en == 4'h0 && !boost_en;
    endproperty
    a_dark: assert property (p_dark) else $error("channel lit outside run state"); // R3
    property p_off_clear;
        state_r == lcfm_pkg::LCFM_OFF |=> faulted_r == 4'h0 && good_r == 4'h0;
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("faults kept through off state"); // R10

    c_expire: cover property (fcond[0] && pwm_period_tick && cnt_r[0] == lim_m1);
    c_lock: cover property (state_r == lcfm_pkg::LCFM_LOCK);
    c_cool: cover property (state_r == lcfm_pkg::LCFM_HOLD ##1 state_r == lcfm_pkg::LCFM_RUN);
    c_limit: cover property (output_overvoltage_limit && active != 4'h0 && good_r != 4'hf);
    c_direct: cover property (direct_pwm_mode && fcond[2] && pwm_period_tick && cnt_r[2] == lim_m1);
endmodule

/* File: lcfm_defs.svh */
// Offsets, reset values and fault time-out counts of the LED channel fault manager.
// Assumes byte addresses on a 32-bit APB with one register per aligned word.
`ifndef LCFM_DEFS_SVH
`define LCFM_DEFS_SVH
`define LCFM_OFF_CTRL 12'h000
`define LCFM_OFF_MASK 12'h004
`define LCFM_OFF_STAT 12'h008
`define LCFM_CTRL_EN 0
`define LCFM_CTRL_LATCH 1
`define LCFM_CTRL_TMO_LSB 8
`define LCFM_EN_RST 1'h0
`define LCFM_LATCH_RST 1'h1
`define LCFM_DTMO_RST 5'h0c
`define LCFM_MASK_RST 4'hf
`define LCFM_TMO_PWM 5'h06
`define LCFM_DTMO_MIN 5'h07
`define LCFM_DTMO_MAX 5'h12
`endif

/* File: lcfm_pkg.sv */
// Types of the LED channel fault manager.
// Assumes four LED strings.
package lcfm_pkg;
    typedef enum logic [1:0] {
        LCFM_OFF = 2'b00,
        LCFM_RUN = 2'b01,
        LCFM_HOLD = 2'b10,
        LCFM_LOCK = 2'b11
    } lcfm_state_t;

    typedef struct packed {
        logic over_short;
        logic at_target;
        logic [7:0] string_forward_drop;
    } lcfm_sense_t;

    typedef struct packed {
        logic [13:0] zero;
        logic [1:0] ref_chan;
        logic [1:0] state;
        logic direct;
        logic otp;
        logic [3:0] good;
        logic [3:0] faulted;
        logic [3:0] on;
    } lcfm_status_t;
endpackage

/* File: lcfm_strings.sv */
// Model of the four LED strings and the boost stage facing the fault manager.
// Assumes the bench picks each string's kind: 0 good, 1 short below threshold, 2 short above, 3 open, 4 zener open.
`timescale 1ns/100ps
module lcfm_strings (
    input wire logic [3:0] led_channel_en,
    input wire logic boost_en,
    input wire logic [3:0][2:0] kind,
    input wire logic vout_push,
    output lcfm_pkg::lcfm_sense_t [3:0] sense,
    output logic output_overvoltage_limit
);
    logic zener_on;
    logic open_on;
    always_comb begin
        zener_on = 1'b0;
        open_on = 1'b0;
        for (int i = 0; i < 4; i++) begin
            zener_on |= led_channel_en[i] && kind[i] == 3'h4;
            open_on |= led_channel_en[i] && kind[i] == 3'h3;
        end
        for (int i = 0; i < 4; i++) begin
            // An open string never reaches its target current
            sense[i].at_target = led_channel_en[i] && kind[i] != 3'h3;
            // Raised output from a zener string lifts the other sinks over the threshold
            sense[i].over_short = led_channel_en[i] && (kind[i] == 3'h2 ||
                (vout_push && zener_on && kind[i] != 3'h4));
            sense[i].string_forward_drop = !led_channel_en[i] ? 8'h00 : kind[i] == 3'h1 ? 8'h10 :
                kind[i] == 3'h4 ? 8'hc0 : 8'h50;
        end
        output_overvoltage_limit = boost_en && open_on;
    end
endmodule

/* File: led_channel_fault_manager_test.sv */
// Self-checking bench of the LED channel fault manager over APB with a string model.
// Assumes an APB slave that may stretch the access phase and outputs settled by the falling clock edge.
`timescale 1ns/100ps
`include "lcfm_defs.svh"
module led_channel_fault_manager_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm_period_tick, direct_pwm_mode;
    logic overtemp_trip, output_overvoltage_limit, input_undervoltage_lockout, boost_en, vout_push;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic e;
    logic [3:0] led_channel_en;
    logic [1:0] reg_ref_chan;
    logic [3:0][2:0] kind;
    lcfm_pkg::lcfm_sense_t [3:0] sense;
    int mismatches, comparisons;
    lcfm_fault_mgr i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
        .pwm_period_tick(pwm_period_tick), .direct_pwm_mode(direct_pwm_mode), .overtemp_trip(overtemp_trip),
        .output_overvoltage_limit(output_overvoltage_limit), .input_undervoltage_lockout(input_undervoltage_lockout),
        .led_channel_en(led_channel_en), .boost_en(boost_en), .reg_ref_chan(reg_ref_chan));
    lcfm_strings i_strings (.led_channel_en(led_channel_en), .boost_en(boost_en), .kind(kind),
        .vout_push(vout_push), .sense(sense), .output_overvoltage_limit(output_overvoltage_limit));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task results();
        $display("Counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Entered just after a rising edge; the answer is taken at the edge where pready is seen high,
    // then the bus is released and one idle edge passes before the next transfer may start
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n == 20) begin
            mismatches++;
            results();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask
    task idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task restart(input logic [31:0] ctrl);
        apb(1'b1, `LCFM_OFF_CTRL, 32'h0);
        apb(1'b1, `LCFM_OFF_CTRL, ctrl);
        idle(3);
    endtask
    task tick(input int n);
        repeat (n) begin
            pwm_period_tick <= 1'b1;
            @(posedge pclk);
            pwm_period_tick <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task outs(input logic [3:0] led, input logic boost);
        @(negedge pclk);
        chk({28'h0, led_channel_en}, {28'h0, led});
        chk({31'h0, boost_en}, {31'h0, boost});
        @(posedge pclk);
    endtask
    initial begin
        mismatches = 0;
        comparisons = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pwm_period_tick = 1'b0;
        direct_pwm_mode = 1'b0;
        overtemp_trip = 1'b0;
        input_undervoltage_lockout = 1'b0;
        vout_push = 1'b0;
        kind = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`LCFM_OFF_CTRL, 32'h0000_0c02, 1'b0);
        rd(`LCFM_OFF_MASK, 32'h0000_000f, 1'b0);
        rd(`LCFM_OFF_STAT, 32'h0, 1'b0);
        rd(12'h00c, 32'h0, 1'b1);
        apb(1'b1, `LCFM_OFF_STAT, 32'hffff_ffff);
        rd(`LCFM_OFF_STAT, 32'h0, 1'b0);
        outs(4'h0, 1'b0);
        restart(32'h0000_0c03);
        outs(4'hf, 1'b1);
        apb(1'b1, `LCFM_OFF_MASK, 32'h7);
        outs(4'h7, 1'b1);
        apb(1'b1, `LCFM_OFF_MASK, 32'hf);
        kind[0] <= 3'h2;
        tick(5);
        outs(4'hf, 1'b1);
        tick(1);
        outs(4'he, 1'b1);
        kind[1] <= 3'h2;
        tick(3);
        kind[1] <= 3'h0;
        tick(1);
        kind[1] <= 3'h2;
        tick(5);
        outs(4'he, 1'b1);
        kind <= '0;
        direct_pwm_mode <= 1'b1;
        restart(32'h0000_0703);
        kind[2] <= 3'h2;
        tick(6);
        outs(4'hf, 1'b1);
        tick(1);
        outs(4'hb, 1'b1);
        restart(32'h0000_1203);
        tick(17);
        outs(4'hf, 1'b1);
        tick(1);
        outs(4'hb, 1'b1);
        restart(32'h0000_0203);
        tick(6);
        outs(4'hf, 1'b1);
        tick(1);
        outs(4'hb, 1'b1);
        restart(32'h0000_1f03);
        tick(17);
        outs(4'hf, 1'b1);
        tick(1);
        outs(4'hb, 1'b1);
        direct_pwm_mode <= 1'b0;
        kind <= {3'h3, 3'h0, 3'h0, 3'h0};
        restart(32'h0000_0c03);
        tick(5);
        outs(4'hf, 1'b1);
        tick(1);
        outs(4'h7, 1'b1);
        kind <= {3'h1, 3'h4, 3'h0, 3'h0};
        restart(32'h0000_0c03);
        tick(8);
        outs(4'hf, 1'b1);
        @(negedge pclk);
        chk({30'h0, reg_ref_chan}, 32'h2);
        @(posedge pclk);
        vout_push <= 1'b1;
        tick(5);
        outs(4'hf, 1'b1);
        tick(1);
        outs(4'h4, 1'b1);
        vout_push <= 1'b0;
        restart(32'h0000_0c01);
        overtemp_trip <= 1'b1;
        idle(2);
        outs(4'h0, 1'b0);
        overtemp_trip <= 1'b0;
        idle(3);
        outs(4'hf, 1'b1);
        restart(32'h0000_0c03);
        overtemp_trip <= 1'b1;
        idle(2);
        overtemp_trip <= 1'b0;
        idle(3);
        outs(4'h0, 1'b0);
        apb(1'b0, `LCFM_OFF_STAT, 32'h0);
        chk({30'h0, q[15:14]}, 32'h3);
        input_undervoltage_lockout <= 1'b1;
        idle(2);
        input_undervoltage_lockout <= 1'b0;
        idle(2);
        apb(1'b0, `LCFM_OFF_STAT, 32'h0);
        chk({30'h0, q[15:14]}, 32'h0);
        outs(4'h0, 1'b0);
        apb(1'b1, `LCFM_OFF_CTRL, 32'h0000_0c03);
        idle(3);
        outs(4'hf, 1'b1);
        results();
    end
endmodule
